// ==== hspdt_pkg.sv ====
// Constants, types and helpers of the host serial port block
package hspdt_pkg;
  // Header bit positions
  localparam int unsigned HDR_AC_BIT = 7;
  localparam int unsigned HDR_RW_BIT = 6;
  // Command codes
  localparam logic [7:0] CMD_STANDBY = 8'h03;
  localparam logic [7:0] CMD_RX = 8'h04;
  localparam logic [7:0] CMD_TX = 8'h05;
  localparam logic [7:0] CMD_WAKE = 8'h06;
  localparam logic [7:0] CMD_SLEEP = 8'h02;
  localparam logic [7:0] CMD_FORCE_STANDBY = 8'h80;
  localparam logic [7:0] CMD_PUT_TX0 = 8'h20;
  localparam logic [7:0] CMD_PUT_TX1 = 8'h21;
  localparam logic [7:0] CMD_FETCH_RX0 = 8'h30;
  localparam logic [7:0] CMD_FETCH_RX1 = 8'h31;
  // Memory map locations
  localparam logic [7:0] DEVTYPE_BASE = 8'h10;
  localparam logic [7:0] DEVTYPE_LAST = 8'h23;
  localparam logic [7:0] RADIO_COMM_ADDR = 8'h90;
  localparam logic [7:0] RADIO_AMP_ADDR = 8'h91;
  localparam logic [7:0] RADIO_FILTER_ADDR = 8'h92;
  localparam logic [7:0] SERIAL_BASE = 8'ha9;
  localparam logic [5:0] ID_BYTES = 6'h03;
  // Framing
  localparam logic [7:0] PREAMBLE_BYTE = 8'haa;
  localparam logic [5:0] PREAMBLE_LEN = 6'h04;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  // Buffers: 256 bits each
  localparam int unsigned BUF_BYTES = 32;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned SYNC_STAGES = 3;

  typedef enum logic [7:0] {
    PH_HDR = 8'h01, PH_ADDR = 8'h02, PH_WR = 8'h04, PH_RD = 8'h08,
    PH_CMD = 8'h10, PH_TXLEN = 8'h20, PH_TXDAT = 8'h40, PH_RXOUT = 8'h80
  } hspdt_phase_e;

  typedef enum logic [3:0] {
    PW_SLEEP = 4'h1, PW_STBY = 4'h2, PW_TX = 4'h4, PW_RX = 4'h8
  } hspdt_power_e;

  typedef enum logic [6:0] {
    FR_IDLE = 7'h01, FR_PRE = 7'h02, FR_ID = 7'h04, FR_LEN = 7'h08,
    FR_PAY = 7'h10, FR_CRC = 7'h20, FR_DRAIN = 7'h40
  } hspdt_framer_e;

  // One byte of the frame checksum, most significant bit first
  function automatic logic [15:0] hspdt_crc_step(input logic [15:0] c,
                                                 input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ d[i]) begin
        r = {r[14:0], 1'b0} ^ CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction
endpackage

// ==== hspdt_top.sv ====
// Host serial slave port, data buffers and direct transfer sequencer
`timescale 1ns/1ps

module hspdt_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  // Depth must be a power of two so the pointers wrap by themselves
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk) begin
    if (!rst_b || flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // hspdt_fifo

module hspdt_top (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic SPI_CS_B,
  input wire logic SPI_SCLK,
  input wire logic SPI_MOSI,
  output logic SPI_MISO_O,
  output logic SPI_MISO_OE,
  output logic CRYSTAL_OSCILLATOR_EN,
  input wire logic LF_CRYSTAL_OSCILLATOR_SEL,
  output logic LF_CRYSTAL_OSCILLATOR_EN,
  output logic LF_RCO_EN,
  output hspdt_pkg::hspdt_power_e POWER_STATE,
  output logic LM_ABORT,
  output logic RADIO_TX_EN,
  output logic RADIO_RX_EN,
  output logic [7:0] COMMUNICATION_SETTING,
  output logic [7:0] AMPLIFIER_LEVEL,
  output logic [7:0] FILTER_SETTING,
  output logic [7:0] TX_DATA,
  output logic TX_VALID,
  input wire logic TX_READY,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic RX_LAST,
  input wire logic RX_CRC_OK,
  output logic RX_READY,
  input wire logic [4:0] DT_INDEX,
  output logic [7:0] DT_BYTE,
  input wire logic [1:0] FLAG_MASK,
  input wire logic [1:0] FLAG_CLR,
  output logic TX_DONE_FLAG,
  output logic RX_DONE_FLAG,
  output logic CRC_OK_FLAG,
  output logic FLAG_IRQ
);
  import hspdt_pkg::*;

  logic [SYNC_STAGES-1:0] cs_s_r, sclk_s_r, mosi_s_r;
  logic cs_f_r, sclk_f_r, mosi_f_r;
  logic sclk_rise, sclk_fall, cs_rise, cs_fall;
  hspdt_phase_e phase_r;
  hspdt_power_e pw_r;
  hspdt_framer_e fr_r;
  logic [2:0] bitcnt_r;
  logic [6:0] shift_r;
  logic [7:0] rx_byte;
  logic byte_done;
  logic rd_cyc_r;
  logic [7:0] addr_r;
  logic [7:0] miso_r;
  logic [7:0] miso_load;
  logic miso_load_en;
  logic [7:0] cmd_r;
  logic cmd_pend_r;
  logic exec;
  logic [7:0] mem_r [256];
  logic [7:0] txbuf_r [2*BUF_BYTES];
  logic [7:0] rxbuf_r [2*BUF_BYTES];
  logic [7:0] tx_len_r [2];
  logic [5:0] rx_cnt_r [2];
  logic tx_sel_r, get_sel_r, rx_act_r;
  logic [5:0] widx_r, ridx_r, rx_wi_r, fcnt_r;
  logic [15:0] crc_r;
  logic [7:0] fbyte;
  logic f_valid, f_ready, f_push;
  logic abort, start_tx, start_rx, tx_finish, rx_finish;
  logic fifo_empty_n;

  // Pins from the host: three stages, change once stages two and three agree
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      cs_s_r <= '1;
      sclk_s_r <= '0;
      mosi_s_r <= '0;
      cs_f_r <= 1'b1;
      sclk_f_r <= 1'b0;
      mosi_f_r <= 1'b0;
    end else begin
      cs_s_r <= {cs_s_r[SYNC_STAGES-2:0], SPI_CS_B};
      sclk_s_r <= {sclk_s_r[SYNC_STAGES-2:0], SPI_SCLK};
      mosi_s_r <= {mosi_s_r[SYNC_STAGES-2:0], SPI_MOSI};
      if (cs_s_r[1] == cs_s_r[2]) cs_f_r <= cs_s_r[2];
      if (sclk_s_r[1] == sclk_s_r[2]) sclk_f_r <= sclk_s_r[2];
      if (mosi_s_r[1] == mosi_s_r[2]) mosi_f_r <= mosi_s_r[2];
    end
  end

  // Clock idles low, so a frame begins after a low level
  assign sclk_rise = !cs_f_r && !sclk_f_r && sclk_s_r[1] && sclk_s_r[2];
  assign sclk_fall = !cs_f_r && sclk_f_r && !sclk_s_r[1] && !sclk_s_r[2];
  assign cs_rise = !cs_f_r && cs_s_r[1] && cs_s_r[2];
  assign cs_fall = cs_f_r && !cs_s_r[1] && !cs_s_r[2];
  // Sample on the rising edge, most significant bit first
  assign rx_byte = {shift_r, mosi_s_r[2]};
  assign byte_done = sclk_rise && (bitcnt_r == 3'h7);
  assign exec = cs_rise && cmd_pend_r;

  // Byte sequencing of one select frame
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || cs_fall) begin
      phase_r <= PH_HDR;
      bitcnt_r <= '0;
      shift_r <= '0;
      rd_cyc_r <= 1'b0;
      addr_r <= '0;
      widx_r <= '0;
      ridx_r <= '0;
    end else if (sclk_rise) begin
      bitcnt_r <= bitcnt_r + 1'b1;
      shift_r <= rx_byte[6:0];
      if (byte_done) begin
        case (phase_r)
          PH_HDR: begin
            rd_cyc_r <= rx_byte[HDR_RW_BIT];
            if (!rx_byte[HDR_AC_BIT]) begin
              phase_r <= PH_ADDR;
            end else if (!rx_byte[HDR_RW_BIT]) begin
              phase_r <= PH_CMD;
            end else begin
              phase_r <= PH_HDR;
            end
          end
          PH_ADDR: begin
            addr_r <= rd_cyc_r ? 8'(rx_byte + 8'h01) : rx_byte;
            phase_r <= rd_cyc_r ? PH_RD : PH_WR;
          end
          PH_WR, PH_RD: addr_r <= 8'(addr_r + 8'h01);
          PH_CMD: begin
            if (rx_byte == CMD_PUT_TX0 || rx_byte == CMD_PUT_TX1) begin
              phase_r <= PH_TXLEN;
            end else if (rx_byte == CMD_FETCH_RX0 ||
                         rx_byte == CMD_FETCH_RX1) begin
              phase_r <= PH_RXOUT;
            end else begin
              phase_r <= PH_HDR;
            end
          end
          PH_TXLEN: phase_r <= PH_TXDAT;
          PH_TXDAT: widx_r <= 6'(widx_r + 6'h01);
          PH_RXOUT: ridx_r <= 6'(ridx_r + 6'h01);
          default: phase_r <= PH_HDR;
        endcase
      end
    end
  end

  // Byte shifted out next, chosen when the previous byte completes
  always_comb begin
    miso_load = 8'h00;
    miso_load_en = 1'b0;
    if (byte_done) begin
      case (phase_r)
        PH_ADDR: begin
          miso_load = mem_r[rx_byte];
          miso_load_en = rd_cyc_r;
        end
        PH_RD: begin
          miso_load = mem_r[addr_r];
          miso_load_en = 1'b1;
        end
        PH_CMD: begin
          miso_load = 8'({2'b00, rx_cnt_r[rx_byte[0]]} - 8'h01);
          miso_load_en = (rx_byte == CMD_FETCH_RX0 ||
                          rx_byte == CMD_FETCH_RX1);
        end
        PH_RXOUT: begin
          miso_load = rxbuf_r[{get_sel_r, ridx_r[4:0]}];
          miso_load_en = 1'b1;
        end
        default: begin
          miso_load = 8'h00;
          miso_load_en = 1'b0;
        end
      endcase
    end
  end

  // Output shifter; the first falling edge after a load holds bit 7
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || cs_fall) begin
      miso_r <= 8'h00;
    end else if (miso_load_en) begin
      miso_r <= miso_load;
    end else if (sclk_fall && bitcnt_r != 3'h0) begin
      miso_r <= {miso_r[6:0], 1'b0};
    end
  end
  assign SPI_MISO_O = miso_r[7];
  assign SPI_MISO_OE = !cs_f_r;

  // Memory map writes
  always_ff @(posedge CORE_CLK) begin
    if (byte_done && phase_r == PH_WR) begin
      mem_r[addr_r] <= rx_byte;
    end
  end

  // Transmit buffer loading; bytes 33 to 64 of the payload are dropped, later ones wrap to the start
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      tx_sel_r <= 1'b0;
      get_sel_r <= 1'b0;
      tx_len_r[0] <= 8'h00;
      tx_len_r[1] <= 8'h00;
    end else if (byte_done) begin
      if (phase_r == PH_CMD) begin
        if (rx_byte == CMD_PUT_TX0 || rx_byte == CMD_PUT_TX1) begin
          tx_sel_r <= rx_byte[0];
        end
        if (rx_byte == CMD_FETCH_RX0 || rx_byte == CMD_FETCH_RX1) begin
          get_sel_r <= rx_byte[0];
        end
      end
      if (phase_r == PH_TXLEN) tx_len_r[tx_sel_r] <= rx_byte;
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (byte_done && phase_r == PH_TXDAT && !widx_r[5]) begin
      txbuf_r[{tx_sel_r, widx_r[4:0]}] <= rx_byte;
    end
  end

  // Commands held until select goes high
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || cs_rise) begin
      cmd_pend_r <= 1'b0;
      cmd_r <= 8'h00;
    end else if (byte_done && phase_r == PH_CMD) begin
      cmd_r <= rx_byte;
      cmd_pend_r <= 1'b1;
    end
  end

  // Transfer requests are only honoured while awake and idle
  assign abort = exec && (cmd_r == CMD_STANDBY || cmd_r == CMD_FORCE_STANDBY ||
                          cmd_r == CMD_SLEEP);
  assign start_tx = exec && cmd_r == CMD_TX && pw_r == PW_STBY;
  assign start_rx = exec && cmd_r == CMD_RX && pw_r == PW_STBY;
  assign rx_finish = pw_r == PW_RX && RX_VALID && RX_LAST;
  assign tx_finish = fr_r == FR_DRAIN && !fifo_empty_n && !abort;

  // Power and transfer state
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      pw_r <= PW_STBY;
    end else if (exec) begin
      case (cmd_r)
        CMD_WAKE: if (pw_r == PW_SLEEP) pw_r <= PW_STBY;
        CMD_SLEEP: pw_r <= PW_SLEEP;
        CMD_STANDBY, CMD_FORCE_STANDBY: pw_r <= PW_STBY;
        CMD_TX: if (start_tx) pw_r <= PW_TX;
        CMD_RX: if (start_rx) pw_r <= PW_RX;
        default: pw_r <= pw_r;
      endcase
    end else if (tx_finish || rx_finish) begin
      pw_r <= PW_STBY;
    end
  end
  assign POWER_STATE = pw_r;
  assign CRYSTAL_OSCILLATOR_EN = (pw_r != PW_SLEEP);
  assign LF_CRYSTAL_OSCILLATOR_EN = LF_CRYSTAL_OSCILLATOR_SEL;
  assign LF_RCO_EN = !LF_CRYSTAL_OSCILLATOR_SEL;
  assign RADIO_TX_EN = (pw_r == PW_TX);
  assign RADIO_RX_EN = (pw_r == PW_RX);
  assign RX_READY = (pw_r == PW_RX);

  // Link manager transfers only stop on the forced standby
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      LM_ABORT <= 1'b0;
    end else begin
      LM_ABORT <= exec && cmd_r == CMD_FORCE_STANDBY;
    end
  end

  // Radio settings captured when a direct transfer starts
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      COMMUNICATION_SETTING <= 8'h00;
      AMPLIFIER_LEVEL <= 8'h00;
      FILTER_SETTING <= 8'h00;
    end else if (start_tx || start_rx) begin
      COMMUNICATION_SETTING <= mem_r[RADIO_COMM_ADDR];
      AMPLIFIER_LEVEL <= mem_r[RADIO_AMP_ADDR];
      FILTER_SETTING <= mem_r[RADIO_FILTER_ADDR];
    end
  end

  // Device type entries for timing recovery and filtering
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      DT_BYTE <= 8'h00;
    end else if ({3'b000, DT_INDEX} <= 8'(DEVTYPE_LAST - DEVTYPE_BASE)) begin
      DT_BYTE <= mem_r[8'(DEVTYPE_BASE + {3'b000, DT_INDEX})];
    end else begin
      DT_BYTE <= 8'h00;
    end
  end

  // Reception into the active buffer: index, serial, then payload
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      rx_wi_r <= '0;
      rx_act_r <= 1'b0;
      rx_cnt_r[0] <= 6'h00;
      rx_cnt_r[1] <= 6'h00;
    end else if (start_rx) begin
      rx_wi_r <= '0;
    end else if (pw_r == PW_RX && RX_VALID && !abort) begin
      if (!rx_wi_r[5]) rx_wi_r <= 6'(rx_wi_r + 6'h01);
      if (RX_LAST) begin
        rx_cnt_r[rx_act_r] <= rx_wi_r[5] ? rx_wi_r : 6'(rx_wi_r + 6'h01);
        rx_act_r <= !rx_act_r;
      end
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (pw_r == PW_RX && RX_VALID && !rx_wi_r[5]) begin
      rxbuf_r[{rx_act_r, rx_wi_r[4:0]}] <= RX_DATA;
    end
  end

  // Framer: preamble, identifier, length, payload, checksum
  always_comb begin
    case (fr_r)
      FR_PRE: fbyte = PREAMBLE_BYTE;
      FR_ID: fbyte = mem_r[8'(SERIAL_BASE + {2'b00, fcnt_r})];
      FR_LEN: fbyte = tx_len_r[tx_sel_r];
      FR_PAY: fbyte = txbuf_r[{tx_sel_r, fcnt_r[4:0]}];
      FR_CRC: fbyte = fcnt_r[0] ? crc_r[7:0] : crc_r[15:8];
      default: fbyte = 8'h00;
    endcase
  end
  assign f_valid = (fr_r != FR_IDLE) && (fr_r != FR_DRAIN);
  assign f_push = f_valid && f_ready; // Stalls while the FIFO is full

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || abort) begin
      fr_r <= FR_IDLE;
      fcnt_r <= '0;
      crc_r <= CRC_INIT;
    end else if (start_tx) begin
      fr_r <= FR_PRE;
      fcnt_r <= '0;
      crc_r <= CRC_INIT;
    end else if (tx_finish) begin
      fr_r <= FR_IDLE;
    end else if (f_push) begin
      fcnt_r <= 6'(fcnt_r + 6'h01);
      if (fr_r != FR_PRE && fr_r != FR_CRC) begin
        crc_r <= hspdt_crc_step(crc_r, fbyte);
      end
      case (fr_r)
        FR_PRE: if (fcnt_r == PREAMBLE_LEN - 6'h01) begin
          fr_r <= FR_ID;
          fcnt_r <= '0;
        end
        FR_ID: if (fcnt_r == ID_BYTES - 6'h01) begin
          fr_r <= FR_LEN;
          fcnt_r <= '0;
        end
        FR_LEN: begin
          fr_r <= FR_PAY;
          fcnt_r <= '0;
        end
        FR_PAY: if (fcnt_r == 6'(BUF_BYTES - 1) ||
                    {2'b00, fcnt_r} == tx_len_r[tx_sel_r]) begin
          fr_r <= FR_CRC;
          fcnt_r <= '0;
        end
        FR_CRC: if (fcnt_r[0]) fr_r <= FR_DRAIN;
        default: fr_r <= FR_IDLE;
      endcase
    end
  end

  // Outgoing byte stream toward the modulator
  hspdt_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .flush(abort),
    .in_valid(f_valid),
    .in_data(fbyte),
    .in_ready(f_ready),
    .out_valid(fifo_empty_n),
    .out_data(TX_DATA),
    .out_ready(TX_READY)
  );
  assign TX_VALID = fifo_empty_n;

  // Sticky completion flags; a new event beats a clear
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      TX_DONE_FLAG <= 1'b0;
      RX_DONE_FLAG <= 1'b0;
      CRC_OK_FLAG <= 1'b0;
    end else begin
      TX_DONE_FLAG <= tx_finish || (TX_DONE_FLAG && !FLAG_CLR[0]);
      RX_DONE_FLAG <= rx_finish || (RX_DONE_FLAG && !FLAG_CLR[1]);
      if (rx_finish) CRC_OK_FLAG <= RX_CRC_OK;
    end
  end
  assign FLAG_IRQ = (TX_DONE_FLAG && !FLAG_MASK[0]) ||
                    (RX_DONE_FLAG && !FLAG_MASK[1]);
endmodule // hspdt_top

// ==== hspdt_host.sv ====
// Host side serial master model: select, bit clock and data out
`timescale 1ns/1ps
module hspdt_host (
  output logic cs_b,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  // Idle: deselected, clock parked low
  initial begin
    cs_b = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // Select, then a settle gap far shorter than the real one to keep runs
  // short; the 0.3 ns offset keeps pin edges off the core clock edges
  task automatic open_frame();
    #0.3 cs_b = 1'b0;
    #48;
  endtask
  // One byte, MSB first; launch on fall, sample on rise
  task automatic xfer(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi = t[i];
      #24 sclk = 1'b1;
      r[i] = miso;
      #24 sclk = 1'b0;
    end
  endtask
  // Deselect after the last fall; data parks at the inverse
  task automatic close_frame();
    #24 cs_b = 1'b1;
    mosi = ~mosi;
    #96;
  endtask
endmodule // hspdt_host

// ==== hspdt_monitor.sv ====
// Checker of the host serial port top-level ports
`timescale 1ns/1ps
module hspdt_monitor (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic SPI_CS_B,
  input wire logic SPI_MISO_OE,
  input wire logic CRYSTAL_OSCILLATOR_EN,
  input wire logic LF_CRYSTAL_OSCILLATOR_SEL,
  input wire logic LF_CRYSTAL_OSCILLATOR_EN,
  input wire logic LF_RCO_EN,
  input wire hspdt_pkg::hspdt_power_e POWER_STATE,
  input wire logic LM_ABORT,
  input wire logic RADIO_TX_EN,
  input wire logic RX_READY,
  input wire logic TX_VALID,
  input wire logic [4:0] DT_INDEX,
  input wire logic [7:0] DT_BYTE,
  input wire logic [1:0] FLAG_MASK,
  input wire logic TX_DONE_FLAG,
  input wire logic RX_DONE_FLAG,
  input wire logic FLAG_IRQ
);
  import hspdt_pkg::*;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // Select sync needs a few cycles, so idle is judged after six
  sequence s_cs_idle; SPI_CS_B [*6]; endsequence
  sequence s_tx_end; $rose(TX_DONE_FLAG); endsequence
  property p_oe_off; s_cs_idle |-> !SPI_MISO_OE; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("data out enabled while deselected");
  property p_crystal_oscillator; CRYSTAL_OSCILLATOR_EN == (POWER_STATE != PW_SLEEP); endproperty
  a_crystal_oscillator: assert property (p_crystal_oscillator)
    else $error("crystal enable wrong for power state");
  property p_lf; LF_CRYSTAL_OSCILLATOR_EN == LF_CRYSTAL_OSCILLATOR_SEL && LF_RCO_EN != LF_CRYSTAL_OSCILLATOR_SEL;
  endproperty
  a_lf: assert property (p_lf)
    else $error("low frequency clock choice wrong");
  property p_rx; RX_READY == (POWER_STATE == PW_RX); endproperty
  a_rx: assert property (p_rx)
    else $error("receive ready outside receive state");
  property p_tx; RADIO_TX_EN == (POWER_STATE == PW_TX); endproperty
  a_tx: assert property (p_tx)
    else $error("transmit enable outside transmit state");
  property p_irq; FLAG_IRQ == (TX_DONE_FLAG && !FLAG_MASK[0] ||
    RX_DONE_FLAG && !FLAG_MASK[1]); endproperty
  a_irq: assert property (p_irq)
    else $error("flag request disagrees with mask");
  property p_exec; $changed(POWER_STATE) && POWER_STATE != PW_STBY |->
    $past(SPI_CS_B, 2); endproperty
  a_exec: assert property (p_exec)
    else $error("command acted while selected");
  property p_abort; LM_ABORT |=> !LM_ABORT && POWER_STATE == PW_STBY;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort pulse wrong");
  property p_tx_end; s_tx_end |-> ##[0:2] (POWER_STATE == PW_STBY &&
    !TX_VALID); endproperty
  a_tx_end: assert property (p_tx_end)
    else $error("no standby after transmit");
  property p_dt; DT_INDEX > 19 |=> DT_BYTE == 8'h00; endproperty
  a_dt: assert property (p_dt)
    else $error("type byte beyond table not zero");
endmodule // hspdt_monitor

bind hspdt_top hspdt_monitor mon (.CORE_CLK, .RST_B, .SPI_CS_B,
  .SPI_MISO_OE, .CRYSTAL_OSCILLATOR_EN, .LF_CRYSTAL_OSCILLATOR_SEL, .LF_CRYSTAL_OSCILLATOR_EN, .LF_RCO_EN,
  .POWER_STATE, .LM_ABORT, .RADIO_TX_EN, .RX_READY, .TX_VALID, .DT_INDEX,
  .DT_BYTE, .FLAG_MASK, .TX_DONE_FLAG, .RX_DONE_FLAG, .FLAG_IRQ);

// ==== hspdt_top_bench.sv ====
// Self-checking bench of the host serial port block
`timescale 1ns/1ps
module hspdt_top_bench;
  import hspdt_pkg::*;
  logic CORE_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic SPI_CS_B, SPI_SCLK, SPI_MOSI, SPI_MISO_O, SPI_MISO_OE, CRYSTAL_OSCILLATOR_EN;
  logic LF_CRYSTAL_OSCILLATOR_SEL, LF_CRYSTAL_OSCILLATOR_EN, LF_RCO_EN, LM_ABORT, RADIO_TX_EN;
  logic RADIO_RX_EN, TX_VALID, TX_READY, RX_VALID, RX_LAST, RX_CRC_OK;
  logic RX_READY, TX_DONE_FLAG, RX_DONE_FLAG, CRC_OK_FLAG, FLAG_IRQ;
  logic [7:0] COMMUNICATION_SETTING, AMPLIFIER_LEVEL, FILTER_SETTING;
  logic [7:0] TX_DATA, RX_DATA, DT_BYTE;
  logic [4:0] DT_INDEX;
  logic [1:0] FLAG_MASK, FLAG_CLR;
  hspdt_power_e POWER_STATE;
  int fail_count = 0;
  int total_checks = 0;
  logic [7:0] mem [256];
  logic [7:0] tq[$], rq[$], eq[$], pl[$];
  logic abort_seen = 1'b0;

  hspdt_top dut (.CORE_CLK, .RST_B, .SPI_CS_B, .SPI_SCLK, .SPI_MOSI,
    .SPI_MISO_O, .SPI_MISO_OE, .CRYSTAL_OSCILLATOR_EN, .LF_CRYSTAL_OSCILLATOR_SEL, .LF_CRYSTAL_OSCILLATOR_EN,
    .LF_RCO_EN, .POWER_STATE, .LM_ABORT, .RADIO_TX_EN, .RADIO_RX_EN,
    .COMMUNICATION_SETTING, .AMPLIFIER_LEVEL, .FILTER_SETTING, .TX_DATA,
    .TX_VALID, .TX_READY, .RX_DATA, .RX_VALID, .RX_LAST, .RX_CRC_OK,
    .RX_READY, .DT_INDEX, .DT_BYTE, .FLAG_MASK, .FLAG_CLR, .TX_DONE_FLAG,
    .RX_DONE_FLAG, .CRC_OK_FLAG, .FLAG_IRQ);
  hspdt_host host (.cs_b(SPI_CS_B), .sclk(SPI_SCLK), .mosi(SPI_MOSI),
    .miso(SPI_MISO_O));

  // Core clock, 5 ns period
  always #2.5 CORE_CLK = ~CORE_CLK;
  // Abort stands one cycle only, so latch it
  always @(posedge CORE_CLK) if (LM_ABORT === 1'b1) abort_seen <= 1'b1;

  task automatic chk(input string w, input logic [31:0] s,
    input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // One selected frame; bytes seen on data out kept in order
  task automatic spi(input logic [7:0] t[$], output logic [7:0] r[$]);
    logic [7:0] b;
    r = {};
    host.open_frame();
    foreach (t[i]) begin
      host.xfer(t[i], b);
      r.push_back(b);
    end
    host.close_frame();
    @(negedge CORE_CLK);
  endtask
  task automatic cmd(input logic [7:0] c);
    spi({8'h80, c}, rq);
    repeat (8) @(negedge CORE_CLK);
  endtask
  task automatic waitst(input hspdt_power_e s);
    int n;
    for (n = 0; n < 3000 && POWER_STATE !== s; n++) @(negedge CORE_CLK);
    if (n == 3000) begin
      fail_count++;
      $display("Error power wait expected %h seen %h", s, POWER_STATE);
      results();
    end
  endtask
  function automatic logic [15:0] crc(input logic [15:0] c,
    input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      c = (c[15] ^ d[i]) ? {c[14:0], 1'b0} ^ CRC_POLY : {c[14:0], 1'b0};
    end
    return c;
  endfunction

  // Main sequence
  initial begin
    int n, m, v;
    logic [15:0] c;
    logic [7:0] d;
    logic [7:0] base [3];
    {TX_READY, RX_VALID, RX_LAST, RX_CRC_OK, LF_CRYSTAL_OSCILLATOR_SEL} = 5'h00;
    {RX_DATA, FLAG_MASK, FLAG_CLR} = 12'h000;
    DT_INDEX = 5'h14;
    base = '{8'h10, 8'h90, 8'ha9};
    v = $urandom(70);
    repeat (2) @(negedge CORE_CLK);
    RST_B = 1'b1;
    @(negedge CORE_CLK);
    chk("reset", {POWER_STATE, TX_VALID, TX_DONE_FLAG},
      {PW_STBY, 2'b00});
    // Burst writes, then burst reads of the same places
    foreach (base[b]) begin
      tq = {8'h00, base[b]};
      for (int i = 0; i < 4; i++) begin
        mem[base[b] + i] = $urandom;
        tq.push_back(mem[base[b] + i]);
      end
      spi(tq, rq);
      spi({8'h40, base[b], 8'h00, 8'h00, 8'h00, 8'h00}, rq);
      for (int i = 0; i < 4; i++) begin
        chk("read", rq[i + 2], mem[base[b] + i]);
      end
    end
    // Type table lookup, inside the written part and beyond the table
    DT_INDEX = 5'($urandom % 4);
    @(negedge CORE_CLK);
    chk("type", DT_BYTE, mem[8'h10 + DT_INDEX]);
    DT_INDEX = 5'(20 + $urandom % 12);
    @(negedge CORE_CLK);
    chk("type out", DT_BYTE, 8'h00);
    LF_CRYSTAL_OSCILLATOR_SEL = 1'b1;
    // Sleep waits for deselect
    host.open_frame();
    host.xfer(8'h80, d);
    host.xfer(CMD_SLEEP, d);
    #200;
    chk("held command", POWER_STATE, PW_STBY);
    chk("select oe", SPI_MISO_OE, 1'b1);
    host.close_frame();
    waitst(PW_SLEEP);
    chk("sleep clocks", {CRYSTAL_OSCILLATOR_EN, LF_CRYSTAL_OSCILLATOR_EN}, 2'b01);
    chk("deselect oe", SPI_MISO_OE, 1'b0);
    cmd(CMD_TX);
    chk("tx refused", POWER_STATE, PW_SLEEP);
    cmd(CMD_WAKE);
    waitst(PW_STBY);
    chk("crystal on", CRYSTAL_OSCILLATOR_EN, 1'b1);
    // Header with both bits set is dropped; the next byte of its frame is taken as a new header
    spi({8'hc0, CMD_SLEEP}, rq);
    repeat (8) @(negedge CORE_CLK);
    chk("bad header", POWER_STATE, PW_STBY);
    // Load a payload; expected frame built alongside
    n = 1 + $urandom % 32;
    tq = {8'h80, CMD_PUT_TX0, 8'(n - 1)};
    eq = {8'haa, 8'haa, 8'haa, 8'haa, mem[8'ha9], mem[8'haa], mem[8'hab],
      8'(n - 1)};
    c = CRC_INIT;
    for (int i = 4; i < 8; i++) c = crc(c, eq[i]);
    for (int i = 0; i < n; i++) begin
      v = $urandom;
      tq.push_back(v[7:0]);
      eq.push_back(v[7:0]);
      c = crc(c, v[7:0]);
    end
    eq.push_back(c[15:8]);
    eq.push_back(c[7:0]);
    spi({8'h80, CMD_PUT_TX1, 8'h00, 8'h5a}, rq);
    spi(tq, rq);
    cmd(CMD_TX);
    chk("tx on", RADIO_TX_EN, 1'b1);
    chk("settings", {COMMUNICATION_SETTING, AMPLIFIER_LEVEL, FILTER_SETTING},
      {mem[8'h90], mem[8'h91], mem[8'h92]});
    // Drain with random stalls; the byte leaves at the next edge
    for (m = 0; m < 4000 && eq.size() > 0; m++) begin
      @(negedge CORE_CLK);
      TX_READY = $urandom % 2;
      if (TX_READY && TX_VALID === 1'b1) begin
        chk("tx", TX_DATA, eq.pop_front());
      end
    end
    chk("tx left", eq.size(), 0);
    waitst(PW_STBY);
    FLAG_MASK = 2'b01;
    @(negedge CORE_CLK);
    chk("masked", {TX_DONE_FLAG, FLAG_IRQ}, 2'b10);
    FLAG_CLR = 2'b01;
    @(negedge CORE_CLK);
    FLAG_CLR = 2'b00;
    @(negedge CORE_CLK);
    chk("cleared", TX_DONE_FLAG, 1'b0);
    // Reception into buffer 0, then fetch it back
    cmd(CMD_RX);
    chk("rx ready", {RX_READY, RADIO_RX_EN}, 2'b11);
    m = 4 + $urandom % 8;
    pl = {};
    for (int i = 0; i < m; i++) begin
      v = $urandom;
      {RX_DATA, RX_VALID, RX_LAST, RX_CRC_OK} = {v[7:0], 1'b1, i == m - 1,
        v[8]};
      pl.push_back(v[7:0]);
      @(negedge CORE_CLK);
    end
    RX_VALID = 1'b0;
    waitst(PW_STBY);
    // Checksum result is random; only the value given with the last byte
    chk("rx flags", {RX_DONE_FLAG, CRC_OK_FLAG}, {1'b1, v[8]});
    tq = {8'h80, CMD_FETCH_RX0};
    for (int i = 0; i <= m; i++) tq.push_back(8'h00);
    spi(tq, rq);
    chk("rx length", rq[2], m - 1);
    for (int i = 0; i < m; i++) begin
      chk("rx", rq[i + 3], pl[i]);
    end
    spi({8'h80, CMD_FETCH_RX1, 8'h00}, rq);
    chk("empty length", rq[2], 8'hff);
    // Aborts: plain standby, then forced standby
    cmd(CMD_RX);
    cmd(CMD_STANDBY);
    chk("standby", {POWER_STATE, RX_READY, CRYSTAL_OSCILLATOR_EN},
      {PW_STBY, 2'b01});
    cmd(CMD_RX);
    cmd(CMD_FORCE_STANDBY);
    chk("forced", {POWER_STATE, abort_seen},
      {PW_STBY, 1'b1});
    results();
  end
endmodule // hspdt_top_bench
